//--- fse_pkg.sv
// Constants shared by the flash error-handling controller files
package fse_pkg;
  localparam int CLK_NS = 5;
  // Flash pin timing, in nanoseconds
  localparam int T_RP_NS = 60;
  localparam int T_RWH_NS = 500;
  localparam int T_WP_NS = 70;
  localparam int T_ACC_NS = 80;
  // Least times, rounded up to whole cycles, with two more cycles added to access
  localparam int RP_CYC = (T_RP_NS + CLK_NS - 1) / CLK_NS;
  localparam int RWH_CYC = (T_RWH_NS + CLK_NS - 1) / CLK_NS;
  localparam int WP_CYC = (T_WP_NS + CLK_NS - 1) / CLK_NS;
  localparam int ACC_CYC = (T_ACC_NS + CLK_NS - 1) / CLK_NS + 2;
  localparam int CNT_W = 8;
  localparam int ADDR_W = 18;
  localparam int DQ_W = 16;
  // Flash command codes
  localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;
  localparam logic [7:0] CMD_READ_STATUS = 8'h70;
  localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h20;
  localparam logic [7:0] CMD_ERASE_CONFIRM = 8'hD0;
  localparam logic [7:0] CMD_WRITE_SETUP = 8'h40;
  // Status byte bit positions
  localparam int SB_READY = 7;
  localparam int SB_ERASE_FAIL = 5;
  localparam int SB_PROG_FAIL = 4;
  localparam int SB_VPP_MISSING = 3;
  // APB register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_DATA = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;
  // Control register fields
  localparam int CTRL_START = 0;
  localparam int CTRL_OP_LSB = 1;
  localparam int CTRL_PD = 8;
  // Status register fields
  localparam int ST_BYTE_LSB = 0;
  localparam int ST_ERR_LSB = 8;
  localparam int ST_BUSY = 16;
  localparam int ST_VPP_LOCK = 17;
  localparam int ST_REFUSED = 18;
  localparam int ST_PWRDN = 19;
  localparam int ST_ARRAY_MODE = 20;
  typedef enum logic [2:0] {
    OP_READ = 3'h0,
    OP_READ_ARRAY = 3'h1,
    OP_READ_STATUS = 3'h2,
    OP_CLEAR = 3'h3,
    OP_PROGRAM = 3'h4,
    OP_ERASE = 3'h5
  } fse_op_t;
endpackage

//--- fse_cycle.sv
// One asynchronous flash bus cycle, read or write
`timescale 1ns/1ps
module fse_cycle import fse_pkg::*; #(
  parameter int WP_CYCLES = WP_CYC,
  parameter int ACC_CYCLES = ACC_CYC
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic req,
  input wire logic wr,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DQ_W-1:0] wdata,
  output logic done,
  output logic [DQ_W-1:0] rdata,
  output logic ce_n,
  output logic we_n,
  output logic oe_n,
  output logic [ADDR_W-1:0] fl_addr,
  output logic [DQ_W-1:0] dq_o,
  output logic dq_oe,
  input wire logic [DQ_W-1:0] dq_i
);
  typedef enum logic [1:0] {E_IDLE, E_SETUP, E_PULSE, E_HOLD} fse_eng_t;
  fse_eng_t st_r;
  logic [CNT_W-1:0] cnt_r;
  logic wr_r;
  logic [DQ_W-1:0] dq_s1_r;
  logic [DQ_W-1:0] dq_s2_r;

  // Data pins come from outside the clock domain
  always_ff @(posedge clk) begin
    dq_s1_r <= dq_i;
    dq_s2_r <= dq_s1_r;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_r <= E_IDLE;
      cnt_r <= '0;
      wr_r <= 1'b0;
      done <= 1'b0;
      rdata <= '0;
      ce_n <= 1'b1;
      we_n <= 1'b1;
      oe_n <= 1'b1;
      fl_addr <= '0;
      dq_o <= '0;
      dq_oe <= 1'b0;
    end else begin
      done <= 1'b0;
      unique case (st_r)
        E_IDLE: begin
          if (req) begin
            st_r <= E_SETUP;
            wr_r <= wr;
            ce_n <= 1'b0;
            oe_n <= wr;
            fl_addr <= addr;
            dq_o <= wdata;
            dq_oe <= wr;
          end
        end
        E_SETUP: begin
          st_r <= E_PULSE;
          we_n <= !wr_r;
          cnt_r <= wr_r ? CNT_W'(WP_CYCLES - 1) : CNT_W'(ACC_CYCLES - 1);
        end
        E_PULSE: begin
          if (cnt_r == '0) begin
            st_r <= E_HOLD;
            we_n <= 1'b1;
            oe_n <= 1'b1;
            if (!wr_r) begin
              rdata <= dq_s2_r;
            end
          end else begin
            cnt_r <= cnt_r - 1'b1;
          end
        end
        E_HOLD: begin
          st_r <= E_IDLE;
          ce_n <= 1'b1;
          dq_oe <= 1'b0;
          done <= 1'b1;
        end
      endcase
    end
  end
endmodule

//--- fse_ctrl.sv
// Host controller for a command-driven flash: sequencing, status polling, error capture
`timescale 1ns/1ps
module fse_ctrl import fse_pkg::*; #(
  parameter int RP_CYCLES = RP_CYC,
  parameter int RWH_CYCLES = RWH_CYC
) (
  input wire logic REF_CLK,
  input wire logic SRST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  output logic FL_CE_N,
  output logic FL_WE_N,
  output logic FL_OE_N,
  output logic FL_RP_N,
  output logic [ADDR_W-1:0] FL_ADDR,
  output logic [DQ_W-1:0] FL_DQ_O,
  output logic FL_DQ_OE,
  input wire logic [DQ_W-1:0] FL_DQ_I
);
  typedef enum logic [2:0] {S_RESET, S_WAKE, S_IDLE, S_FIRST, S_SECOND, S_POLL, S_READ, S_PD} fse_state_t;
  fse_state_t state_r;
  logic [CNT_W-1:0] cnt_r;
  logic [ADDR_W-1:0] addr_r;
  logic [DQ_W-1:0] data_r;
  logic [7:0] cmd1_r;
  logic [7:0] cmd2_r;
  logic [7:0] sbyte_r;
  logic [2:0] err_r;
  logic vpp_lock_r;
  logic refused_r;
  logic pd_r;
  logic array_mode_r;
  logic eng_req_r;
  logic eng_wr_r;
  logic [ADDR_W-1:0] eng_addr_r;
  logic [DQ_W-1:0] eng_wdata_r;
  logic pend_r;
  logic op_is_read_r;
  logic eng_done;
  logic [DQ_W-1:0] eng_rdata;
  logic apb_setup;
  logic apb_wr;
  logic start;
  fse_op_t op;

  function automatic logic [2:0] err_code(input logic [7:0] sb);
    err_code = {sb[SB_ERASE_FAIL], sb[SB_PROG_FAIL], sb[SB_VPP_MISSING]};
  endfunction

  assign apb_setup = PSEL && !PENABLE && !PREADY;
  assign apb_wr = PSEL && PENABLE && PREADY && PWRITE && !PSLVERR;
  assign start = apb_wr && PADDR == REG_CTRL && PWDATA[CTRL_START];
  assign op = fse_op_t'(PWDATA[CTRL_OP_LSB +: 3]);

  // APB slave: no wait states, answer registered in the setup cycle
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA <= '0;
    end else begin
      PREADY <= apb_setup;
      PSLVERR <= apb_setup && !(PADDR inside {REG_CTRL, REG_ADDR, REG_DATA, REG_STATUS});
      PRDATA <= '0;
      if (apb_setup && !PWRITE) begin
        unique case (PADDR)
          REG_CTRL: PRDATA <= 32'(pd_r) << CTRL_PD;
          REG_ADDR: PRDATA <= 32'(addr_r);
          REG_DATA: PRDATA <= 32'(data_r);
          REG_STATUS: PRDATA <= {11'h000, array_mode_r, pd_r, refused_r, vpp_lock_r, state_r != S_IDLE,
                                 5'h00, err_r, sbyte_r};
          default: PRDATA <= '0;
        endcase
      end
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      addr_r <= '0;
      pd_r <= 1'b0;
    end else if (apb_wr) begin
      if (PADDR == REG_ADDR) begin
        addr_r <= PWDATA[ADDR_W-1:0];
      end
      if (PADDR == REG_CTRL) begin
        pd_r <= PWDATA[CTRL_PD];
      end
    end
  end

  // Sequencer for flash command cycles
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      state_r <= S_RESET;
      cnt_r <= '0;
      FL_RP_N <= 1'b0;
      data_r <= '0;
      cmd1_r <= CMD_READ_ARRAY;
      cmd2_r <= CMD_READ_ARRAY;
      sbyte_r <= '0;
      err_r <= '0;
      vpp_lock_r <= 1'b0;
      refused_r <= 1'b0;
      array_mode_r <= 1'b1;
      eng_req_r <= 1'b0;
      eng_wr_r <= 1'b0;
      eng_addr_r <= '0;
      eng_wdata_r <= '0;
      pend_r <= 1'b0;
      op_is_read_r <= 1'b0;
    end else begin
      eng_req_r <= 1'b0;
      if (apb_wr && PADDR == REG_DATA && state_r == S_IDLE) begin
        data_r <= PWDATA[DQ_W-1:0];
      end
      if (apb_wr && PADDR == REG_STATUS && PWDATA[ST_REFUSED]) begin
        refused_r <= 1'b0;
      end
      // Start during a running command is dropped; the set beats a same-cycle clear
      if (start && !(state_r inside {S_IDLE, S_RESET, S_WAKE, S_PD})) begin
        refused_r <= 1'b1;
      end
      unique case (state_r)
        S_RESET: begin
          if (cnt_r == CNT_W'(RP_CYCLES - 1)) begin
            FL_RP_N <= 1'b1;
            cnt_r <= '0;
            state_r <= S_WAKE;
          end else begin
            cnt_r <= cnt_r + 1'b1;
          end
        end
        S_WAKE: begin
          if (cnt_r == CNT_W'(RWH_CYCLES - 1)) begin
            cnt_r <= '0;
            array_mode_r <= 1'b1;
            state_r <= S_IDLE;
          end else begin
            cnt_r <= cnt_r + 1'b1;
          end
        end
        S_IDLE: begin
          if (pd_r) begin
            FL_RP_N <= 1'b0;
            cnt_r <= '0;
            state_r <= S_PD;
          end else if (start) begin
            state_r <= S_FIRST;
            op_is_read_r <= op == OP_READ;
            unique case (op)
              OP_READ: begin
                cmd1_r <= CMD_READ_ARRAY;
                if (array_mode_r) begin
                  state_r <= S_READ;
                end
              end
              OP_READ_ARRAY: cmd1_r <= CMD_READ_ARRAY;
              OP_READ_STATUS: cmd1_r <= CMD_READ_STATUS;
              OP_CLEAR: cmd1_r <= CMD_CLEAR_STATUS;
              OP_PROGRAM, OP_ERASE: begin
                cmd1_r <= op == OP_PROGRAM ? CMD_WRITE_SETUP : CMD_ERASE_SETUP;
                cmd2_r <= op == OP_PROGRAM ? data_r[7:0] : CMD_ERASE_CONFIRM;
                if (vpp_lock_r) begin
                  refused_r <= 1'b1;
                  state_r <= S_IDLE;
                end
              end
              default: begin
                refused_r <= 1'b1;
                state_r <= S_IDLE;
              end
            endcase
          end
        end
        S_FIRST: begin
          if (!pend_r) begin
            eng_req_r <= 1'b1;
            eng_wr_r <= 1'b1;
            eng_addr_r <= addr_r;
            eng_wdata_r <= {8'h00, cmd1_r};
            pend_r <= 1'b1;
          end else if (eng_done) begin
            pend_r <= 1'b0;
            unique case (cmd1_r)
              CMD_READ_ARRAY: begin
                array_mode_r <= 1'b1;
                state_r <= op_is_read_r ? S_READ : S_IDLE;
              end
              CMD_READ_STATUS: begin
                array_mode_r <= 1'b0;
                state_r <= S_READ;
              end
              CMD_CLEAR_STATUS: begin
                vpp_lock_r <= 1'b0;
                err_r <= '0;
                state_r <= S_IDLE;
              end
              default: state_r <= S_SECOND;
            endcase
          end
        end
        S_SECOND: begin
          if (!pend_r) begin
            eng_req_r <= 1'b1;
            eng_wdata_r <= cmd1_r == CMD_WRITE_SETUP ? data_r : {8'h00, cmd2_r};
            pend_r <= 1'b1;
          end else if (eng_done) begin
            pend_r <= 1'b0;
            array_mode_r <= 1'b0;
            state_r <= S_POLL;
          end
        end
        S_POLL: begin
          if (!pend_r) begin
            eng_req_r <= 1'b1;
            eng_wr_r <= 1'b0;
            pend_r <= 1'b1;
          end else if (eng_done) begin
            pend_r <= 1'b0;
            sbyte_r <= eng_rdata[7:0];
            if (eng_rdata[SB_READY]) begin
              err_r <= err_code(eng_rdata[7:0]);
              vpp_lock_r <= eng_rdata[SB_VPP_MISSING];
              state_r <= S_IDLE;
            end
          end
        end
        S_READ: begin
          if (!pend_r) begin
            eng_req_r <= 1'b1;
            eng_wr_r <= 1'b0;
            eng_addr_r <= addr_r;
            pend_r <= 1'b1;
          end else if (eng_done) begin
            pend_r <= 1'b0;
            data_r <= eng_rdata;
            if (!array_mode_r) begin
              sbyte_r <= eng_rdata[7:0];
              if (eng_rdata[SB_READY]) begin
                err_r <= err_code(eng_rdata[7:0]);
                vpp_lock_r <= eng_rdata[SB_VPP_MISSING];
              end
            end
            state_r <= S_IDLE;
          end
        end
        S_PD: begin
          // Least low pulse on reset/power-down even if software wakes at once
          if (cnt_r != CNT_W'(RP_CYCLES - 1)) begin
            cnt_r <= cnt_r + 1'b1;
          end else if (!pd_r) begin
            FL_RP_N <= 1'b1;
            cnt_r <= '0;
            state_r <= S_WAKE;
          end
        end
      endcase
    end
  end

  fse_cycle u_cycle (
    .clk(REF_CLK),
    .srst(SRST),
    .req(eng_req_r),
    .wr(eng_wr_r),
    .addr(eng_addr_r),
    .wdata(eng_wdata_r),
    .done(eng_done),
    .rdata(eng_rdata),
    .ce_n(FL_CE_N),
    .we_n(FL_WE_N),
    .oe_n(FL_OE_N),
    .fl_addr(FL_ADDR),
    .dq_o(FL_DQ_O),
    .dq_oe(FL_DQ_OE),
    .dq_i(FL_DQ_I)
  );

  property p_reset_holds_rp;
    @(posedge REF_CLK) disable iff (SRST)
    $fell(SRST) |-> (!FL_RP_N && FL_CE_N && FL_WE_N) [*8];
  endproperty
  a_reset_holds_rp: assert property (p_reset_holds_rp) else $error("RP released too early");

  property p_busy_poll_keeps_err;
    @(posedge REF_CLK) disable iff (SRST)
    (state_r == S_POLL && pend_r && eng_done && !eng_rdata[SB_READY]) |=> $stable(err_r) && state_r == S_POLL;
  endproperty
  a_busy_poll_keeps_err: assert property (p_busy_poll_keeps_err) else $error("Error taken while busy");

  property p_ready_captures_err;
    @(posedge REF_CLK) disable iff (SRST)
    (state_r == S_POLL && pend_r && eng_done && eng_rdata[SB_READY])
      |=> err_r == {$past(eng_rdata[5]), $past(eng_rdata[4]), $past(eng_rdata[3])} && state_r == S_IDLE;
  endproperty
  a_ready_captures_err: assert property (p_ready_captures_err) else $error("Error code not captured");

  property p_read_after_op_sends_ffh;
    @(posedge REF_CLK) disable iff (SRST)
    (state_r == S_IDLE && !pd_r && start && op == OP_READ && !array_mode_r)
      |=> state_r == S_FIRST && cmd1_r == CMD_READ_ARRAY;
  endproperty
  a_read_after_op_sends_ffh: assert property (p_read_after_op_sends_ffh) else $error("No FFH before read");

  property p_vpp_lock_refuses;
    @(posedge REF_CLK) disable iff (SRST)
    (state_r == S_IDLE && !pd_r && start && vpp_lock_r && (op == OP_PROGRAM || op == OP_ERASE))
      |=> state_r == S_IDLE && refused_r ##1 !eng_req_r;
  endproperty
  a_vpp_lock_refuses: assert property (p_vpp_lock_refuses) else $error("Operation started with voltage flag");
endmodule

//--- fse_flash_model.sv
// Behavioural model of the command-driven flash on the controller's far side
`timescale 1ns/1ps
module fse_flash_model import fse_pkg::*; #(
  parameter int BUSY_CYC = 40
) (
  input wire logic clk,
  input wire logic ce_n,
  input wire logic we_n,
  input wire logic oe_n,
  input wire logic rp_n,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DQ_W-1:0] dq_o,
  input wire logic dq_oe,
  input wire logic vpp_ok,
  input wire logic fail_inj,
  output logic [DQ_W-1:0] dq_i
);
  logic we_q = 1'b1;
  logic vf = 1'b0, pf = 1'b0, ef = 1'b0, arr = 1'b1, ps = 1'b0, es = 1'b0, fp = 1'b0, fe = 1'b0;
  int busy = 0;
  logic [DQ_W-1:0] mem = '0;
  logic [DQ_W-1:0] last = '0;
  logic [7:0] sr;
  logic drv;
  assign sr = {busy == 0, 1'b0, ef, pf, vf, 3'b000};
  assign drv = !ce_n && !oe_n && rp_n;
  // Released bus shows a pattern that flips every cycle while RP is high, and stays all ones while RP is low
  assign dq_i = drv ? (arr ? mem ^ addr[DQ_W-1:0] : {8'h00, sr}) : dq_oe ? dq_o : ~last;
  always @(posedge clk) begin
    we_q <= we_n;
    last <= dq_i;
    if (!rp_n) begin
      {vf, pf, ef, ps, es} <= 5'h00;
      last <= '0;
      arr <= 1'b1;
      busy <= 0;
    end else begin
      if (busy > 0) busy <= busy - 1;
      if (busy == 1) begin
        pf <= pf | fp;
        ef <= ef | fe;
      end
      if (!we_q && we_n && !ce_n && busy == 0) begin
        if (ps || es) begin
          {ps, es} <= 2'h0;
          arr <= 1'b0;
          if (es && dq_o[7:0] != CMD_ERASE_CONFIRM) {pf, ef} <= 2'h3;
          else if (!vpp_ok) vf <= 1'b1;
          else if (!vf) begin
            busy <= BUSY_CYC;
            fp <= fail_inj && ps;
            fe <= fail_inj && es;
            if (ps) mem <= dq_o;
          end
        end else begin
          case (dq_o[7:0])
            CMD_READ_ARRAY: arr <= 1'b1;
            CMD_READ_STATUS: arr <= 1'b0;
            CMD_CLEAR_STATUS: {vf, pf, ef} <= 3'h0;
            CMD_ERASE_SETUP: {es, arr} <= 2'h2;
            CMD_WRITE_SETUP: {ps, arr} <= 2'h2;
            default: ;
          endcase
        end
      end
    end
  end
endmodule

//--- flash_status_error_handling_tb.sv
// Self-checking bench for the flash error-handling controller
`timescale 1ns/1ps
module flash_status_error_handling_tb import fse_pkg::*;;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, st;
  logic pready, pslverr, ce_n, we_n, oe_n, rp_n, dq_oe, err_seen;
  logic [ADDR_W-1:0] fl_addr;
  logic [DQ_W-1:0] dq_o, dq_i;
  logic vpp_ok = 1'b1, fail_inj = 1'b0;
  int fail_count = 0, check_count = 0;
  // Per row: err code, fail, vpp present, op
  logic [7:0] rows [15] = '{8'h0C, 8'h5C, 8'h4C, 8'hDD, 8'hE4, 8'h0B, 8'h9D, 8'hA5,
    8'h0B, 8'h24, 8'h2C, 8'h0B, 8'h5C, 8'h64, 8'h0B};
  fse_ctrl #(.RP_CYCLES(12), .RWH_CYCLES(4)) DUT (.REF_CLK(clk), .SRST(srst), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .FL_CE_N(ce_n), .FL_WE_N(we_n), .FL_OE_N(oe_n),
    .FL_RP_N(rp_n), .FL_ADDR(fl_addr), .FL_DQ_O(dq_o), .FL_DQ_OE(dq_oe), .FL_DQ_I(dq_i));
  fse_flash_model #(.BUSY_CYC(40)) FLASH (.clk(clk), .ce_n(ce_n), .we_n(we_n), .oe_n(oe_n),
    .rp_n(rp_n), .addr(fl_addr), .dq_o(dq_o), .dq_oe(dq_oe), .vpp_ok(vpp_ok),
    .fail_inj(fail_inj), .dq_i(dq_i));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %0t %s: got %h expected %h", $time, msg, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    st = prdata;
    err_seen = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) check(1'h0, 1'h1, "no pready");
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    do begin
      apb(1'b0, REG_STATUS, 32'h0000_0000);
      n++;
    end while (st[ST_BUSY] !== 1'b0 && n < 500);
    if (n >= 500) check(1'h0, 1'h1, "busy stuck");
  endtask
  task automatic run(input fse_op_t op);
    apb(1'b1, REG_CTRL, (32'(op) << CTRL_OP_LSB) | 32'h0000_0001);
    wait_idle();
  endtask
  task automatic t_reset();
    wait_idle();
    check(st[10:8], 3'h0, "err after reset");
    check(st[ST_ARRAY_MODE], 1'h1, "array mode");
    check({rp_n, ce_n}, 2'h3, "idle pins");
    apb(1'b0, 8'h10, 32'h0000_0000);
    check(err_seen, 1'h1, "unmapped");
  endtask
  task automatic t_prog_read();
    apb(1'b1, REG_ADDR, 32'h0000_0155);
    apb(1'b1, REG_DATA, 32'h0000_1234);
    run(OP_PROGRAM);
    check(st[7:0], 8'h80, "status byte");
    check(st[ST_ARRAY_MODE], 1'h0, "status mode");
    run(OP_READ);
    apb(1'b0, REG_DATA, 32'h0000_0000);
    check(st[15:0], 16'h1234 ^ 16'h0155, "read back");
    apb(1'b0, REG_STATUS, 32'h0000_0000);
    check(st[ST_ARRAY_MODE], 1'h1, "array again");
  endtask
  task automatic t_table();
    logic [7:0] r;
    logic lock;
    lock = 1'b0;
    foreach (rows[i]) begin
      r = rows[i];
      vpp_ok <= r[3];
      fail_inj <= r[4];
      run(fse_op_t'(r[2:0]));
      check(st[10:8], r[7:5], "err code");
      check(st[ST_VPP_LOCK], r[5], "vpp lock");
      check(st[ST_REFUSED], lock && r[2], "refused");
      lock = r[5];
      apb(1'b1, REG_STATUS, 32'h0004_0000);
    end
  endtask
  task automatic t_power();
    fail_inj <= 1'b1;
    run(OP_PROGRAM);
    fail_inj <= 1'b0;
    apb(1'b1, REG_CTRL, 32'h0000_0100);
    repeat (4) @(posedge clk);
    check(rp_n, 1'h0, "rp low");
    apb(1'b0, REG_STATUS, 32'h0000_0000);
    check(st[ST_PWRDN], 1'h1, "power-down");
    apb(1'b1, REG_CTRL, 32'h0000_0000);
    repeat (12) @(posedge clk);
    wait_idle();
    run(OP_READ_STATUS);
    check(st[7:0], 8'h80, "status after wake");
    check(st[10:8], 3'h0, "err after wake");
    run(OP_READ_ARRAY);
    check(st[ST_ARRAY_MODE], 1'h1, "array after FFH");
    // Last programmed word is the earlier read-back, so the address mask restores it
    run(OP_READ);
    apb(1'b0, REG_DATA, 32'h0000_0000);
    check(st[15:0], 16'h1234, "array read after wake");
    apb(1'b1, REG_CTRL, 32'h0000_0005);
    apb(1'b1, REG_CTRL, 32'h0000_0005);
    wait_idle();
    check(st[ST_REFUSED], 1'h1, "start while busy");
  endtask
  task automatic results();
    $display("checks %0d failures %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    forever #2.5 clk = ~clk;
  end
  initial begin
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    t_reset();
    t_prog_read();
    t_table();
    t_power();
    results();
  end
  initial begin
    #200000;
    fail_count++;
    results();
  end
endmodule
